// >>> hw/exp_bus_map.vh
// Register addresses, reset values and bus-phase timing counts.
// Assumes inclusion by the bus and port pin block and its bench.
`ifndef EXP_BUS_MAP_VH
`define EXP_BUS_MAP_VH

// Register block placement
`define REG_BLOCK_DEFAULT 16'h1000
`define REG_BLOCK_END 16'h1060
`define RST_BLOCK_NIB 4'h1

// Register addresses with the block at its default place
`define ADDR_PORT_A 16'h1000
`define ADDR_DDR_A 16'h1001
`define ADDR_PORT_G 16'h1002
`define ADDR_DDR_G 16'h1003
`define ADDR_PORT_B 16'h1004
`define ADDR_PORT_F 16'h1005
`define ADDR_PORT_C 16'h1006
`define ADDR_DDR_C 16'h1007
`define ADDR_PORT_D 16'h1008
`define ADDR_DDR_D 16'h1009
`define ADDR_PORT_E 16'h100A
`define ADDR_BLOCK_BASE 16'h105A
`define ADDR_MODE_STAT 16'h105B

// Reset values
`define RST_DATA 8'h00
`define RST_DIR 8'h00

// Port D width and base field position
`define PORT_D_W 6
`define BASE_LSB 4

// Oscillator cycles per bus-phase clock and per phase
`define OSC_PER_BUS 4
`define E_LOW_CYC 3'h2
`define E_HIGH_CYC 3'h2
`define E_STRETCH_CYC 3'h4

`endif

// >>> hw/expanded_bus_and_port_pins.v
// Expanded bus phase logic, mode latch, reset pin and parallel port pins.
// Assumes clock_i is the oscillator; core requests are on the same clock.
//
// The address-and-strobe port was decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "exp_bus_map.vh"

// Function
// - Bus-phase clock derived from oscillator, one quarter its frequency.
// - Address driven only in low phase, data bus driven only in high phase.
// - Inverted strobe output always the inverse of bus-phase clock.
// - Stretch input sampled at every bus-phase clock rising edge.
// - Stretch sampled high holds the clock high four oscillator cycles.
// - Stretch sampled low brings clock low two oscillator cycles after rise.
// - Reset pin resets the block; failures pull it low, open drain.
// - Mode pins held during reset, latched at reset to pick the mode.
// - After reset mode pin A pulses open drain at instruction start.
// - Direction output shows read or write in expanded and test modes.
// - Port B output only: general outputs or address high byte.
// - Port F output only: general outputs or address low byte.
// - Port C is data bus when expanded, else direction-governed I/O.
// - Port A pins are inputs after reset until software changes direction.
// - Port D gives six I/O lines with data and direction registers.
// - Port E is an eight-bit input-only port.
// - Chip selects replace port G upper four pins when enabled.
// - Low interrupt input raises an interrupt request to the core.
// - Registers sit in a relocatable 96-byte block, default base at start.
module expanded_bus_and_port_pins (
  input wire clock_i,
  input wire sys_rst_i,
  input wire ce_i,
  input wire [15:0] reg_addr_i,
  input wire [7:0] reg_wdata_i,
  input wire reg_wr_i,
  input wire reg_rd_i,
  output reg [7:0] reg_rdata_o,
  input wire ext_req_i,
  input wire ext_write_i,
  input wire [15:0] ext_addr_i,
  input wire [7:0] ext_wdata_i,
  output reg [7:0] ext_rdata_o,
  output reg ext_done_o,
  output wire ext_busy_o,
  output reg e_clk_o,
  output reg inverted_strobe_out_o,
  input wire stretch_i,
  output reg rw_o,
  output reg addr_oe_n_o,
  input wire reset_pin_n_i,
  output wire reset_pin_o,
  output reg reset_pin_oe_n_o,
  input wire clock_fail_i,
  input wire watchdog_fail_i,
  output wire mcu_rst_o,
  input wire mode_select_a_i,
  input wire mode_select_b_i,
  output wire [1:0] mode_o,
  input wire instr_start_i,
  output wire instr_start_flag_o,
  output reg instr_start_flag_oe_n_o,
  input wire irq_n_i,
  output wire irq_req_o,
  input wire [7:0] port_a_i,
  output wire [7:0] port_a_o,
  output wire [7:0] port_a_oe_n_o,
  output reg [7:0] port_b_o,
  input wire [7:0] port_c_i,
  output reg [7:0] port_c_o,
  output reg [7:0] port_c_oe_n_o,
  input wire [5:0] port_d_i,
  output wire [5:0] port_d_o,
  output wire [5:0] port_d_oe_n_o,
  input wire [7:0] port_e_i,
  output reg [7:0] port_f_o,
  input wire [7:0] port_g_i,
  output reg [7:0] port_g_o,
  output reg [7:0] port_g_oe_n_o,
  input wire cs_enable_i,
  input wire [3:0] chip_sel_n_i
);

  localparam SW = 43;
  localparam ST_LOW = 1'b0;
  localparam ST_HIGH = 1'b1;

  reg [SW-1:0] sync1;
  reg [SW-1:0] sync2;
  reg rst_q;
  reg [1:0] mode;
  reg stretched;
  reg [2:0] e_cnt;
  reg active;
  reg xwr;
  reg [15:0] xaddr;
  reg [7:0] xwdata;
  reg [7:0] data_a;
  reg [7:0] ddr_a;
  reg [7:0] data_b;
  reg [7:0] data_c;
  reg [7:0] ddr_c;
  reg [5:0] data_d;
  reg [5:0] ddr_d;
  reg [7:0] data_f;
  reg [7:0] data_g;
  reg [7:0] ddr_g;
  reg [3:0] base_nib;
  reg [7:0] next_rdata;
  reg [2:0] last;
  reg next_e_high;

  wire [7:0] pa_s;
  wire [7:0] pc_s;
  wire [5:0] pd_s;
  wire [7:0] pe_s;
  wire [7:0] pg_s;
  wire stretch_s;
  wire mode_select_a_s;
  wire mode_select_b_s;
  wire rstn_s;
  wire irqn_s;
  wire expanded;
  wire e_end;
  wire fall_next;
  wire take;
  wire fin;
  wire [15:0] rel_addr;
  wire mapped;
  wire [3:0] nib_off;

  // Every pin input passes two flops before use
  always @(posedge clock_i)
  begin
    if (ce_i)
    begin
      if (sys_rst_i)
      begin
        sync1 <= {SW{1'b0}};
        sync2 <= {SW{1'b0}};
      end
      else
      begin
        sync1 <= {port_a_i, port_c_i, port_d_i, port_e_i, port_g_i,
          stretch_i, mode_select_a_i, mode_select_b_i, reset_pin_n_i,
          irq_n_i};
        sync2 <= sync1;
      end
    end
  end

  assign pa_s = sync2[42:35];
  assign pc_s = sync2[34:27];
  assign pd_s = sync2[26:21];
  assign pe_s = sync2[20:13];
  assign pg_s = sync2[12:5];
  assign stretch_s = sync2[4];
  assign mode_select_a_s = sync2[3];
  assign mode_select_b_s = sync2[2];
  assign rstn_s = sync2[1];
  assign irqn_s = sync2[0];

  assign irq_req_o = ~irqn_s;

  // reset from system or pin, failures drive the pin low
  always @(posedge clock_i)
  begin
    if (ce_i)
    begin
      rst_q <= sys_rst_i | ~rstn_s;
      reset_pin_oe_n_o <= ~(clock_fail_i | watchdog_fail_i);
    end
  end
  assign mcu_rst_o = rst_q;
  assign reset_pin_o = 1'b0;

  // mode follows the pins for as long as reset holds
  always @(posedge clock_i)
  begin
    if (ce_i && rst_q)
      mode <= {mode_select_b_s, mode_select_a_s};
  end
  assign mode_o = mode;
  assign expanded = mode[0];

  // open-drain instruction start pulse, pin is an input in reset
  always @(posedge clock_i)
  begin
    if (ce_i)
      instr_start_flag_oe_n_o <= rst_q | ~instr_start_i;
  end
  assign instr_start_flag_o = 1'b0;

  always @*
  begin
    if (e_clk_o == ST_HIGH)
      last = (stretched ? `E_STRETCH_CYC : `E_HIGH_CYC) - 3'h1;
    else
      last = `E_LOW_CYC - 3'h1;
  end
  assign e_end = (e_cnt == last);
  assign fall_next = e_clk_o & e_end;

  always @*
  begin
    case (e_clk_o)
      ST_LOW: next_e_high = e_end;
      ST_HIGH: next_e_high = ~e_end;
      default: next_e_high = 1'b0;
    endcase
  end

  always @(posedge clock_i)
  begin
    if (ce_i)
    begin
      if (rst_q)
      begin
        e_clk_o <= ST_LOW;
        inverted_strobe_out_o <= 1'b1;
        e_cnt <= 3'h0;
        stretched <= 1'b0;
      end
      else
      begin
        e_clk_o <= next_e_high;
        inverted_strobe_out_o <= ~next_e_high;
        e_cnt <= e_end ? 3'h0 : e_cnt + 3'h1;
        if (~e_clk_o & e_end)
          stretched <= stretch_s;
      end
    end
  end

  // Requests are taken at a falling edge and end at the next one
  assign take = fall_next & ~active & ext_req_i & expanded;
  assign fin = fall_next & active;
  assign ext_busy_o = active;

  always @(posedge clock_i)
  begin
    if (ce_i)
    begin
      if (rst_q)
      begin
        active <= 1'b0;
        xwr <= 1'b0;
        xaddr <= 16'h0000;
        xwdata <= 8'h00;
        ext_rdata_o <= 8'h00;
        ext_done_o <= 1'b0;
        rw_o <= 1'b1;
      end
      else
      begin
        ext_done_o <= fin;
        if (take)
        begin
          active <= 1'b1;
          xwr <= ext_write_i;
          xaddr <= ext_addr_i;
          xwdata <= ext_wdata_i;
        end
        else if (fin)
          active <= 1'b0;
        // Sync delay samples the last low-phase cycle, or the high phase when stretched
        if (fin & ~xwr)
          ext_rdata_o <= pc_s;
        rw_o <= ~((take & ext_write_i) | (active & ~fin & xwr));
      end
    end
  end

  // address pins enabled in low phase, data driven in high phase
  always @(posedge clock_i)
  begin
    if (ce_i)
    begin
      if (rst_q)
      begin
        addr_oe_n_o <= 1'b1;
        port_b_o <= `RST_DATA;
        port_f_o <= `RST_DATA;
        port_c_o <= `RST_DATA;
        port_c_oe_n_o <= 8'hFF;
        port_g_o <= `RST_DATA;
        port_g_oe_n_o <= 8'hFF;
      end
      else
      begin
        addr_oe_n_o <= ~(expanded & ~next_e_high);
        port_b_o <= expanded ? (take ? ext_addr_i[15:8] : xaddr[15:8])
          : data_b;
        port_f_o <= expanded ? (take ? ext_addr_i[7:0] : xaddr[7:0])
          : data_f;
        port_c_o <= expanded ? xwdata : data_c;
        port_c_oe_n_o <= expanded
          ? {8{~(active & ~fin & xwr & next_e_high)}} : ~ddr_c;
        // chip selects on upper port G pins
        port_g_o <= cs_enable_i ? {chip_sel_n_i, data_g[3:0]} : data_g;
        port_g_oe_n_o <= cs_enable_i ? {4'h0, ~ddr_g[3:0]} : ~ddr_g;
      end
    end
  end

  assign port_a_o = data_a;
  assign port_a_oe_n_o = ~ddr_a;
  assign port_d_o = data_d;
  assign port_d_oe_n_o = ~ddr_d;

  // relocated block decode, base nibble moves the 96 bytes
  assign nib_off = reg_addr_i[15:12] - base_nib + `RST_BLOCK_NIB;
  assign rel_addr = {nib_off, reg_addr_i[11:0]};
  assign mapped = (rel_addr >= `REG_BLOCK_DEFAULT)
    && (rel_addr < `REG_BLOCK_END);

  always @(posedge clock_i)
  begin
    if (ce_i)
    begin
      if (rst_q)
      begin
        data_a <= `RST_DATA;
        ddr_a <= `RST_DIR;
        data_b <= `RST_DATA;
        data_c <= `RST_DATA;
        ddr_c <= `RST_DIR;
        data_d <= 6'h00;
        ddr_d <= 6'h00;
        data_f <= `RST_DATA;
        data_g <= `RST_DATA;
        ddr_g <= `RST_DIR;
        base_nib <= `RST_BLOCK_NIB;
      end
      else if (reg_wr_i && mapped)
      begin
        case (rel_addr)
          `ADDR_PORT_A: data_a <= reg_wdata_i;
          `ADDR_DDR_A: ddr_a <= reg_wdata_i;
          `ADDR_PORT_G: data_g <= reg_wdata_i;
          `ADDR_DDR_G: ddr_g <= reg_wdata_i;
          `ADDR_PORT_B: data_b <= reg_wdata_i;
          `ADDR_PORT_F: data_f <= reg_wdata_i;
          `ADDR_PORT_C: data_c <= reg_wdata_i;
          `ADDR_DDR_C: ddr_c <= reg_wdata_i;
          `ADDR_PORT_D: data_d <= reg_wdata_i[`PORT_D_W-1:0];
          `ADDR_DDR_D: ddr_d <= reg_wdata_i[`PORT_D_W-1:0];
          `ADDR_BLOCK_BASE: base_nib <= reg_wdata_i[7:`BASE_LSB];
          default: data_a <= data_a;
        endcase
      end
    end
  end

  // Pin reads: outputs show the latch, inputs the pin
  always @*
  begin
    next_rdata = 8'h00;
    case (rel_addr)
      `ADDR_PORT_A: next_rdata = (ddr_a & data_a) | (~ddr_a & pa_s);
      `ADDR_DDR_A: next_rdata = ddr_a;
      `ADDR_PORT_G: next_rdata = (ddr_g & data_g) | (~ddr_g & pg_s);
      `ADDR_DDR_G: next_rdata = ddr_g;
      `ADDR_PORT_B: next_rdata = data_b;
      `ADDR_PORT_F: next_rdata = data_f;
      `ADDR_PORT_C: next_rdata = expanded ? pc_s
        : ((ddr_c & data_c) | (~ddr_c & pc_s));
      `ADDR_DDR_C: next_rdata = ddr_c;
      `ADDR_PORT_D: next_rdata = {2'h0, (ddr_d & data_d) | (~ddr_d & pd_s)};
      `ADDR_DDR_D: next_rdata = {2'h0, ddr_d};
      // input only; timing is left to software
      `ADDR_PORT_E: next_rdata = pe_s;
      `ADDR_BLOCK_BASE: next_rdata = {base_nib, 4'h0};
      `ADDR_MODE_STAT: next_rdata = {6'h00, mode};
      default: next_rdata = 8'h00;
    endcase
    if (!mapped)
      next_rdata = 8'h00;
  end

  always @(posedge clock_i)
  begin
    if (ce_i)
    begin
      if (rst_q)
        reg_rdata_o <= 8'h00;
      else if (reg_rd_i)
        reg_rdata_o <= next_rdata;
      else
        reg_rdata_o <= 8'h00;
    end
  end

endmodule // expanded_bus_and_port_pins
`default_nettype wire

// >>> testbench/bus_pins_checker_assertions.sv
// Checker for bus-phase timing and bus pin drive.
// Bound to the pin block; sees its ports only.
`timescale 1ns/1ps
`default_nettype none
module bus_pins_checker (
  input wire clock_i,
  input wire sys_rst_i,
  input wire e_clk_o,
  input wire inverted_strobe_out_o,
  input wire addr_oe_n_o,
  input wire rw_o,
  input wire ext_done_o,
  input wire ext_busy_o,
  input wire ext_write_i,
  input wire [15:0] ext_addr_i,
  input wire [7:0] port_b_o,
  input wire [7:0] port_f_o,
  input wire [7:0] port_c_oe_n_o,
  input wire [1:0] mode_o,
  input wire mcu_rst_o,
  input wire clock_fail_i,
  input wire watchdog_fail_i,
  input wire reset_pin_oe_n_o,
  input wire instr_start_i,
  input wire instr_start_flag_oe_n_o,
  input wire irq_n_i,
  input wire irq_req_o
);
  default clocking @(posedge clock_i);
  endclocking
  // Internal reset outlasts the system reset by the pin synchroniser
  default disable iff (sys_rst_i || mcu_rst_o);
  strobe_inverse_a: assert property (
    inverted_strobe_out_o == !e_clk_o) else $error("strobe bad");
  low_phase_a: assert property (
    $fell(e_clk_o) |-> !e_clk_o[*2] ##1 e_clk_o) else $error("low phase");
  high_phase_a: assert property (
    $rose(e_clk_o) |-> e_clk_o[*2] ##1
    (!e_clk_o or e_clk_o[*2] ##1 !e_clk_o)) else $error("high phase");
  addr_low_a: assert property (
    !addr_oe_n_o |-> !e_clk_o) else $error("addr in high");
  data_high_a: assert property (
    mode_o[0] && port_c_oe_n_o != 8'hFF |-> e_clk_o)
    else $error("data in low");
  done_fall_a: assert property (
    ext_done_o |-> $fell(e_clk_o)) else $error("done off fall");
  write_dir_a: assert property (
    !rw_o |-> ext_busy_o) else $error("rw idle low");
  addr_out_a: assert property (
    $rose(ext_busy_o) && mode_o[0] |-> rw_o == !$past(ext_write_i)
    && {port_b_o, port_f_o} == $past(ext_addr_i)) else $error("addr");
  fail_pull_a: assert property (
    clock_fail_i || watchdog_fail_i |=> !reset_pin_oe_n_o)
    else $error("reset pin not pulled");
  instr_mark_a: assert property (
    !mcu_rst_o && instr_start_i |=> !instr_start_flag_oe_n_o)
    else $error("no instruction mark");
  instr_idle_a: assert property (
    !instr_start_i |=> instr_start_flag_oe_n_o)
    else $error("stray instruction mark");
  irq_pass_a: assert property (
    irq_req_o == !$past(irq_n_i, 2)) else $error("irq request");
  cover property ($rose(e_clk_o) ##1 e_clk_o[*3]);
  cover property ($fell(mcu_rst_o) && !mode_o[0]);
  cover property (ext_done_o && !$past(rw_o));
  cover property (ext_done_o && $past(rw_o));
endmodule // bus_pins_checker
bind expanded_bus_and_port_pins bus_pins_checker i_chk (.*);
`default_nettype wire

// >>> testbench/ext_mem_model.sv
// Memory on the expanded bus: address on B/F, data on port C.
// Assumes E and R/W come straight from the pin block.
`timescale 1ns/1ps
`default_nettype none
module ext_mem_model (
  input wire logic clock_i,
  input wire logic e_clk_i,
  input wire logic rw_i,
  input wire logic [15:0] addr_i,
  input wire logic [7:0] data_i,
  input wire logic slow_i,
  output logic [7:0] data_o,
  output logic stretch_o
);
  logic [7:0] mem [0:255];
  logic [7:0] junk = 8'h5A;
  assign stretch_o = slow_i;
  // Released bus shows a moving pattern, not the last value
  assign data_o = rw_i ? mem[addr_i[7:0]] : junk;
  always @(posedge clock_i)
  begin
    junk <= ~junk;
    if (e_clk_i && !rw_i)
      mem[addr_i[7:0]] <= data_i;
  end
endmodule // ext_mem_model
`default_nettype wire

// >>> testbench/expanded_bus_and_port_pins_bench.sv
// Bench: register bus, expanded bus with a memory, port pins.
// Assumes one clock; inputs move at rising edges.
`timescale 1ns/1ps
`default_nettype none
`include "exp_bus_map.vh"
module expanded_bus_and_port_pins_bench;
  logic clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, rd_d = 1'b0;
  logic req = 1'b0, wrt = 1'b0, slow = 1'b0, cur_rd = 1'b0;
  logic flt = 1'b0, cse = 1'b0, bsy;
  logic [7:0] pgo, pgoe;
  logic ma = 1'b1, mb = 1'b1, e, rwo, done, stch, rpo;
  logic [15:0] ra = '0, ea = '0, a;
  logic [7:0] wd = '0, ed = '0, pa = '0, pe = '0, pd = '0, pg = '0;
  logic [7:0] dir, v, rdo, erd, pb, pf, pco, pcoe, pci, mdl, aoe;
  logic [7:0] rq[$], eq[$];
  int err_total = 0, total_checks = 0, cyc = 0, i;
  // Wire level of port C: whoever enables wins
  assign pci = (pcoe & mdl) | (~pcoe & pco);
  expanded_bus_and_port_pins i_expanded_bus_and_port_pins (
    .clock_i(clk), .sys_rst_i(rst), .ce_i(1'b1), .reg_addr_i(ra),
    .reg_wdata_i(wd), .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdo),
    .ext_req_i(req), .ext_write_i(wrt), .ext_addr_i(ea), .ext_wdata_i(ed),
    .ext_rdata_o(erd), .ext_done_o(done), .ext_busy_o(bsy), .e_clk_o(e),
    .inverted_strobe_out_o(), .stretch_i(stch), .rw_o(rwo),
    .addr_oe_n_o(), .reset_pin_n_i(rpo), .reset_pin_o(),
    .reset_pin_oe_n_o(rpo), .clock_fail_i(1'b0), .watchdog_fail_i(flt),
    .mcu_rst_o(), .mode_select_a_i(ma), .mode_select_b_i(mb), .mode_o(),
    .instr_start_i(cyc[0] & cyc[2]), .instr_start_flag_o(),
    .instr_start_flag_oe_n_o(), .irq_n_i(cyc[4]), .irq_req_o(),
    .port_a_i(pa), .port_a_o(), .port_a_oe_n_o(aoe), .port_b_o(pb),
    .port_c_i(pci), .port_c_o(pco), .port_c_oe_n_o(pcoe),
    .port_d_i(pd[5:0]), .port_d_o(), .port_d_oe_n_o(), .port_e_i(pe),
    .port_f_o(pf), .port_g_i(pg), .port_g_o(pgo), .port_g_oe_n_o(pgoe),
    .cs_enable_i(cse), .chip_sel_n_i(pg[7:4]));
  ext_mem_model i_ext_mem_model (.clock_i(clk), .e_clk_i(e), .rw_i(rwo),
    .addr_i({pb, pf}), .data_i(pci), .slow_i(slow), .data_o(mdl),
    .stretch_o(stch));
  initial
  begin
    forever #5 clk = ~clk;
  end
  task automatic chk(input logic [7:0] g, input logic [7:0] x);
    total_checks++;
    if (g !== x)
    begin
      err_total++;
      $display("[FAIL] t=%0t got %h exp %h", $time, g, x);
    end
  endtask
  task automatic finish_test;
    err_total += rq.size() + eq.size();
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic reg_wr(input logic [15:0] ad, input logic [7:0] d);
    @(posedge clk);
    ra <= ad;
    wd <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic reg_rd(input logic [15:0] ad, input logic [7:0] x);
    @(posedge clk);
    ra <= ad;
    rd <= 1'b1;
    rq.push_back(x);
    @(posedge clk);
    rd <= 1'b0;
  endtask
  // Request held until done is seen, bounded wait
  task automatic ext_op(input logic w, input logic [15:0] ad,
                        input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk);
    req <= 1'b1;
    wrt <= w;
    ea <= ad;
    ed <= d;
    cur_rd <= !w;
    if (!w)
      eq.push_back(d);
    do @(posedge clk); while (done !== 1'b1 && ++n < 40);
    // A transfer that never ends counts as a mismatch
    if (done !== 1'b1)
      err_total++;
    req <= 1'b0;
  endtask
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    rd_d <= rd;
    if (rd_d)
      chk(rdo, rq.pop_front());
    if (done === 1'b1 && cur_rd)
      chk(erd, eq.pop_front());
    if (cyc == 3000)
    begin
      err_total++;
      finish_test;
    end
  end
  initial
  begin
    void'($urandom(32'h578d));
    pa <= 8'($urandom);
    pe <= 8'($urandom);
    pd <= 8'($urandom);
    pg <= 8'($urandom);
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    repeat (8) @(posedge clk);
    // pins move after reset; latched mode stays
    {ma, mb} <= 2'b00;
    reg_rd(`ADDR_DDR_A, `RST_DIR);
    chk(aoe, 8'hFF);
    reg_rd(`ADDR_PORT_A, pa);
    reg_rd(`ADDR_PORT_B, `RST_DATA);
    reg_rd(`ADDR_MODE_STAT, 8'h03);
    reg_rd(16'h1040, 8'h00);
    reg_wr(`ADDR_PORT_E, ~pe);
    reg_rd(`ADDR_PORT_E, pe);
    $display("reset and map test ended");
    dir = 8'($urandom);
    v = 8'($urandom);
    reg_wr(`ADDR_DDR_A, dir);
    reg_wr(`ADDR_PORT_A, v);
    reg_rd(`ADDR_PORT_A, (dir & v) | (~dir & pa));
    chk(aoe, ~dir);
    reg_wr(`ADDR_DDR_D, 8'hFF);
    reg_wr(`ADDR_PORT_D, v);
    reg_rd(`ADDR_PORT_D, {2'b00, v[5:0]});
    cse <= 1'b1;
    reg_wr(`ADDR_DDR_G, dir);
    reg_wr(`ADDR_PORT_G, v);
    repeat (2) @(posedge clk);
    chk(pgo, {pg[7:4], v[3:0]});
    chk(pgoe, {4'h0, ~dir[3:0]});
    $display("port test ended");
    reg_wr(`ADDR_PORT_B, v);
    reg_wr(`ADDR_BLOCK_BASE, 8'h20);
    reg_rd(`ADDR_PORT_B, 8'h00);
    reg_rd(16'h2004, v);
    reg_wr(16'h205A, 8'h10);
    reg_rd(`ADDR_PORT_B, v);
    $display("relocation test ended");
    for (i = 0; i < 4; i++)
    begin
      a = {1'b1, 15'($urandom)};
      v = 8'($urandom);
      slow <= i[0];
      ext_op(1'b1, a, v);
      ext_op(1'b0, a, v);
    end
    $display("expanded bus test ended");
    // Failure pulls the pin low; reset relatches mode pins, now 00
    flt <= 1'b1;
    repeat (3) @(posedge clk);
    chk({7'h0, rpo}, 8'h00);
    flt <= 1'b0;
    repeat (8) @(posedge clk);
    reg_rd(`ADDR_MODE_STAT, 8'h00);
    reg_rd(`ADDR_PORT_B, `RST_DATA);
    reg_wr(`ADDR_PORT_B, v);
    reg_wr(`ADDR_PORT_F, ~v);
    reg_wr(`ADDR_DDR_C, 8'hFF);
    reg_wr(`ADDR_PORT_C, v);
    repeat (2) @(posedge clk);
    chk(pb, v);
    chk(pf, ~v);
    chk(pcoe, 8'h00);
    chk(pco, v);
    reg_rd(`ADDR_PORT_C, v);
    // Core requests are refused in single-chip mode
    req <= 1'b1;
    repeat (8)
    begin
      @(posedge clk);
      chk({7'h0, bsy}, 8'h00);
    end
    req <= 1'b0;
    $display("fault reset and single-chip test ended");
    finish_test;
  end
endmodule // expanded_bus_and_port_pins_bench
`default_nettype wire
